// ---- hdl/clock_monitor_defs.svh ----
// Offsets, field positions, reset values and timing counts
`ifndef CLOCK_MONITOR_DEFS_SVH
`define CLOCK_MONITOR_DEFS_SVH
`define ADDR_OSC_CONTROL 4'h0
`define ADDR_CLOCK_DIVISOR 4'h1
`define ADDR_STATUS 4'h2
`define OSC_NEW_SEL_HI 10
`define OSC_NEW_SEL_LO 8
`define OSC_CLK_FAIL_BIT 3
`define DIV_RECOVER_BIT 15
`define DIV_RATIO_HI 14
`define DIV_RATIO_LO 12
`define DIV_DOZE_EN_BIT 11
`define DIV_RATIO_RESET 3'h0
`define OSC_SEL_FAST_RC 3'h0
`define MODE_SLEEP 1'h0
`define MODE_IDLE 1'h1
`define WAKE_CYCLES 3'h2
`endif

// ---- hdl/clock_monitor_pkg.sv ----
// Types for the clock monitor and power-save controller
package clock_monitor_pkg;
  typedef enum logic [1:0] {
    PM_RUN = 2'h0,
    PM_ENTER = 2'h1,
    PM_LOW = 2'h3,
    PM_WAKE = 2'h2
  } pm_state_t;

  typedef struct packed {
    logic sleep_clock_off;
    logic cpu_clock_run;
    logic periph_clock_run;
    logic low_power_rc_osc_run;
    logic monitor_active;
    logic wdt_clear;
    logic sys_clock_on;
  } power_ctl_t;

  typedef struct packed {
    pm_state_t pm;
    logic low_is_idle;
    logic pending_wake;
    logic [2:0] wake_count;
    logic [2:0] new_osc_select;
    logic [2:0] active_osc;
    logic pll_on_fallback;
    logic clk_fail;
    logic fail_trap;
    logic recover_on_interrupt;
    logic [2:0] doze_ratio;
    logic doze_enable;
    logic [6:0] doze_count;
    logic cpu_tick;
    logic [15:0] read_data;
    power_ctl_t ctl;
    logic fail_s1;
    logic fail_s2;
  } state_t;
endpackage

// ---- hdl/clock_monitor_power_save_ctrl.sv ----
// Clock fail-safe monitor and power-save controller
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "clock_monitor_defs.svh"

module clock_monitor_power_save_ctrl #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic config_locked_in,
  input wire logic monitor_enable_in,
  input wire logic wdt_enable_in,
  input wire logic pll_in_use_in,
  input wire logic osc_fail_in,
  input wire logic power_save_exec_in,
  input wire logic power_save_mode_in,
  input wire logic irq_in,
  input wire logic wdt_timeout_in,
  output logic [15:0] rdata_out,
  output logic [2:0] clock_select_out,
  output logic pll_fallback_out,
  output logic fail_trap_out,
  output logic cpu_clock_en_out,
  output logic periph_clock_en_out,
  output logic sys_clock_on_out,
  output logic low_power_rc_osc_run_out,
  output logic monitor_active_out,
  output logic wdt_clear_out
);

  clock_monitor_pkg::state_t s;
  clock_monitor_pkg::state_t next_s;
  logic fail_edge;
  logic [6:0] doze_limit;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    next_s.fail_s1 = osc_fail_in;
    next_s.fail_s2 = s.fail_s1;
    next_s.fail_trap = 1'b0;
    next_s.ctl.wdt_clear = 1'b0;
    next_s.read_data = 16'h0000;
    doze_limit = 7'(({7'h00, 1'b1} << s.doze_ratio) - 8'h01);
    fail_edge = s.fail_s2 && monitor_enable_in && !s.clk_fail
      && !s.ctl.sleep_clock_off;

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        `ADDR_OSC_CONTROL: begin
          if (!config_locked_in) begin
            next_s.new_osc_select = wdata_in[`OSC_NEW_SEL_HI:`OSC_NEW_SEL_LO];
            next_s.active_osc = wdata_in[`OSC_NEW_SEL_HI:`OSC_NEW_SEL_LO];
          end
          if (!wdata_in[`OSC_CLK_FAIL_BIT]) begin
            next_s.clk_fail = 1'b0;
          end
        end
        `ADDR_CLOCK_DIVISOR: begin
          next_s.recover_on_interrupt = wdata_in[`DIV_RECOVER_BIT];
          if (!s.doze_enable) begin
            next_s.doze_ratio = wdata_in[`DIV_RATIO_HI:`DIV_RATIO_LO];
          end
          if (!wdata_in[`DIV_DOZE_EN_BIT]) begin
            next_s.doze_enable = 1'b0;
          end else if (next_s.doze_ratio != 3'h0) begin
            next_s.doze_enable = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Read mux
    if (rd_in) begin
      unique case (addr_in)
        `ADDR_OSC_CONTROL: begin
          next_s.read_data[`OSC_NEW_SEL_HI:`OSC_NEW_SEL_LO] = s.new_osc_select;
          next_s.read_data[`OSC_CLK_FAIL_BIT] = s.clk_fail;
        end
        `ADDR_CLOCK_DIVISOR: begin
          next_s.read_data[`DIV_RECOVER_BIT] = s.recover_on_interrupt;
          next_s.read_data[`DIV_RATIO_HI:`DIV_RATIO_LO] = s.doze_ratio;
          next_s.read_data[`DIV_DOZE_EN_BIT] = s.doze_enable;
        end
        `ADDR_STATUS: begin
          next_s.read_data[1:0] = s.pm;
          next_s.read_data[2] = s.low_is_idle;
          next_s.read_data[6:4] = s.active_osc;
        end
        default: begin
        end
      endcase
    end

    // Fail-safe switch, set wins over clear
    if (fail_edge) begin
      next_s.clk_fail = 1'b1;
      next_s.fail_trap = 1'b1;
      next_s.active_osc = `OSC_SEL_FAST_RC;
      next_s.pll_on_fallback = pll_in_use_in;
    end

    // Doze, interrupt recovery
    if (irq_in && s.recover_on_interrupt) begin
      next_s.doze_enable = 1'b0;
    end
    next_s.cpu_tick = 1'b1;
    if (s.doze_enable && !(irq_in && s.recover_on_interrupt)) begin
      next_s.cpu_tick = (s.doze_count == doze_limit);
      next_s.doze_count = (s.doze_count >= doze_limit) ? 7'h00 : 7'(s.doze_count + 7'h01);
    end else begin
      next_s.doze_count = 7'h00;
    end

    // Power-save sequencing
    unique case (s.pm)
      clock_monitor_pkg::PM_RUN: begin
        if (power_save_exec_in) begin
          next_s.pm = clock_monitor_pkg::PM_ENTER;
          next_s.low_is_idle = power_save_mode_in;
          next_s.pending_wake = irq_in;
          next_s.ctl.wdt_clear = wdt_enable_in;
        end
      end
      clock_monitor_pkg::PM_ENTER: begin
        next_s.pm = clock_monitor_pkg::PM_LOW;
        next_s.pending_wake = s.pending_wake || irq_in;
      end
      clock_monitor_pkg::PM_LOW: begin
        if (s.pending_wake || irq_in || wdt_timeout_in) begin
          next_s.pm = clock_monitor_pkg::PM_WAKE;
          next_s.pending_wake = 1'b0;
          next_s.wake_count = 3'h0;
        end
      end
      clock_monitor_pkg::PM_WAKE: begin
        next_s.wake_count = 3'(s.wake_count + 3'h1);
        if (s.wake_count == 3'(`WAKE_CYCLES - 3'h1)) begin
          next_s.pm = clock_monitor_pkg::PM_RUN;
        end
      end
      default: begin
      end
    endcase

    // Clock enables from next mode
    next_s.ctl.sleep_clock_off = (next_s.pm == clock_monitor_pkg::PM_LOW)
      && !next_s.low_is_idle;
    next_s.ctl.cpu_clock_run = (next_s.pm == clock_monitor_pkg::PM_RUN)
      && next_s.cpu_tick;
    next_s.ctl.periph_clock_run = !next_s.ctl.sleep_clock_off;
    next_s.ctl.sys_clock_on = !next_s.ctl.sleep_clock_off;
    next_s.ctl.monitor_active = monitor_enable_in && !next_s.ctl.sleep_clock_off;
    next_s.ctl.low_power_rc_osc_run = next_s.ctl.sleep_clock_off ? wdt_enable_in
      : (monitor_enable_in || wdt_enable_in);
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.pm <= clock_monitor_pkg::PM_RUN;
      s.doze_ratio <= `DIV_RATIO_RESET;
      s.ctl.cpu_clock_run <= 1'b1;
      s.ctl.periph_clock_run <= 1'b1;
      s.ctl.sys_clock_on <= 1'b1;
      s.cpu_tick <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_out = s.read_data;
  assign clock_select_out = s.active_osc;
  assign pll_fallback_out = s.pll_on_fallback;
  assign fail_trap_out = s.fail_trap;
  assign cpu_clock_en_out = s.ctl.cpu_clock_run;
  assign periph_clock_en_out = s.ctl.periph_clock_run;
  assign sys_clock_on_out = s.ctl.sys_clock_on;
  assign low_power_rc_osc_run_out = s.ctl.low_power_rc_osc_run;
  assign monitor_active_out = s.ctl.monitor_active;
  assign wdt_clear_out = s.ctl.wdt_clear;

  ////////////////////////////////////////////////////////////////////
  // Checks
  sleep_clock_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && !s.low_is_idle) |-> !sys_clock_on_out)
    else $error("system clock on in sleep");
  idle_periph_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && s.low_is_idle) |-> periph_clock_en_out
    && !cpu_clock_en_out)
    else $error("idle clocks wrong");
  sleep_monitor_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !sys_clock_on_out |-> !monitor_active_out)
    else $error("monitor active in sleep");
  wdt_clear_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_RUN && power_save_exec_in && wdt_enable_in)
    |=> wdt_clear_out)
    else $error("watchdog not cleared");
  fail_switch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(fail_trap_out) |-> clock_select_out == `OSC_SEL_FAST_RC && s.clk_fail)
    else $error("fallback not taken");
  wake_time_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && irq_in) |-> ##[2:4] (s.pm == clock_monitor_pkg::PM_RUN))
    else $error("wake too slow");
  deferred_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_ENTER && (s.pending_wake || irq_in))
    |=> s.pm == clock_monitor_pkg::PM_LOW
    ##1 s.pm == clock_monitor_pkg::PM_WAKE)
    else $error("deferred wake lost");
  ratio_lock_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.doze_enable && wr_in && addr_in == `ADDR_CLOCK_DIVISOR) |=> $stable(s.doze_ratio))
    else $error("ratio changed in doze");
  doze_guard_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.doze_ratio == 3'h0 && !s.doze_enable) |=> !s.doze_enable)
    else $error("doze set at ratio zero");
  recover_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_in && s.recover_on_interrupt) |=> !s.doze_enable)
    else $error("recover did not clear doze");
  low_power_rc_osc_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && s.low_is_idle && $stable(wdt_enable_in)
    && wdt_enable_in) |-> low_power_rc_osc_run_out)
    else $error("low_power_rc_osc off in idle");
  low_power_rc_osc_monitor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (monitor_enable_in && next_s.pm != clock_monitor_pkg::PM_LOW)
    |=> low_power_rc_osc_run_out)
    else $error("low_power_rc_osc off with monitor enabled");
  trap_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fail_trap_out
    |=> !fail_trap_out)
    else $error("trap longer than one cycle");
  detect_trap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.fail_s2 && monitor_enable_in && sys_clock_on_out && !s.clk_fail)
    |=> fail_trap_out && s.clk_fail)
    else $error("failure not trapped");
  pll_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fail_trap_out
    |-> pll_fallback_out == $past(pll_in_use_in))
    else $error("fallback pll choice wrong");
  pll_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !fail_trap_out
    |-> $stable(pll_fallback_out))
    else $error("fallback pll changed without failure");
  osc_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `ADDR_OSC_CONTROL && !config_locked_in && !fail_edge)
    |=> clock_select_out == $past(wdata_in[`OSC_NEW_SEL_HI:`OSC_NEW_SEL_LO]))
    else $error("oscillator select not taken");
  osc_locked_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `ADDR_OSC_CONTROL && config_locked_in)
    |=> $stable(s.new_osc_select))
    else $error("locked select changed");
  run_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_RUN && !power_save_exec_in)
    |=> s.pm == clock_monitor_pkg::PM_RUN)
    else $error("power save without instruction");
  mode_latch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_RUN && power_save_exec_in)
    |=> s.pm == clock_monitor_pkg::PM_ENTER && s.low_is_idle == $past(power_save_mode_in))
    else $error("power save mode not latched");
  sleep_cpu_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !sys_clock_on_out
    |-> !cpu_clock_en_out)
    else $error("cpu clock on in sleep");
  idle_sys_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && s.low_is_idle)
    |-> sys_clock_on_out)
    else $error("system clock off in idle");
  wake_timeout_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && wdt_timeout_in)
    |=> s.pm == clock_monitor_pkg::PM_WAKE)
    else $error("timeout did not wake");
  low_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_LOW && !s.pending_wake && !irq_in && !wdt_timeout_in)
    |=> s.pm == clock_monitor_pkg::PM_LOW)
    else $error("woke without a source");
  sleep_no_trap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.ctl.sleep_clock_off
    |=> !fail_trap_out)
    else $error("monitor trapped in sleep");
  sleep_low_power_rc_osc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wdt_enable_in && next_s.pm == clock_monitor_pkg::PM_LOW)
    |=> low_power_rc_osc_run_out)
    else $error("low_power_rc_osc off with watchdog in low power");
  wdt_clear_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wdt_clear_out
    |-> s.pm == clock_monitor_pkg::PM_ENTER)
    else $error("watchdog clear outside entry");
  sleep_periph_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !sys_clock_on_out
    |-> !periph_clock_en_out)
    else $error("peripheral clock on in sleep");
  clock_kept_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(clock_select_out)
    |-> fail_trap_out || ($past(wr_in) && $past(addr_in) == `ADDR_OSC_CONTROL))
    else $error("clock source changed by itself");
  idle_low_power_rc_osc_mon_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (monitor_enable_in && next_s.pm == clock_monitor_pkg::PM_LOW && next_s.low_is_idle)
    |=> low_power_rc_osc_run_out)
    else $error("low_power_rc_osc off with monitor in idle");
  wake_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.pm == clock_monitor_pkg::PM_WAKE
    |-> s.wake_count < `WAKE_CYCLES)
    else $error("wake counter overran");
  wake_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.pm == clock_monitor_pkg::PM_WAKE
    |-> ##[1:2] s.pm == clock_monitor_pkg::PM_RUN)
    else $error("wake sequence too long");
  pending_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.pm == clock_monitor_pkg::PM_RUN && power_save_exec_in && irq_in)
    |=> s.pending_wake)
    else $error("coincident interrupt lost");
  wake_clears_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.pm == clock_monitor_pkg::PM_WAKE
    |-> !s.pending_wake)
    else $error("pending wake left set");
  doze_periph_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.doze_enable && s.pm == clock_monitor_pkg::PM_RUN)
    |-> periph_clock_en_out)
    else $error("peripheral clock slowed in doze");
  doze_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.doze_enable
    |-> s.doze_count <= doze_limit)
    else $error("doze counter beyond limit");
  full_speed_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!$past(s.doze_enable) && s.pm == clock_monitor_pkg::PM_RUN)
    |-> cpu_clock_en_out)
    else $error("cpu clock gated without doze");
  limit_max_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.doze_ratio == 3'h7
    |-> doze_limit == 7'h7F)
    else $error("ratio 111 not divide by 128");
  limit_mid_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.doze_ratio == 3'h3
    |-> doze_limit == 7'h07)
    else $error("ratio 011 not divide by 8");
  recover_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (irq_in && !s.recover_on_interrupt && s.doze_enable && !wr_in)
    |=> s.doze_enable)
    else $error("interrupt left doze without recover");
  ratio_nonzero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s.doze_enable
    |-> s.doze_ratio != 3'h0)
    else $error("doze on with ratio zero");
  flag_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($past(rd_in) && $past(addr_in) == `ADDR_OSC_CONTROL)
    |-> rdata_out[`OSC_CLK_FAIL_BIT] == $past(s.clk_fail))
    else $error("fail flag read wrong");
  flag_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s.clk_fail && !(wr_in && addr_in == `ADDR_OSC_CONTROL))
    |=> s.clk_fail)
    else $error("fail flag dropped by itself");
endmodule

// ---- verification/osc_core_model.sv ----
// Far-side model: oscillator source and CPU clock consumer
`timescale 1ns/1ps

module osc_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sys_on_in,
  input wire logic kill_in,
  input wire logic cpu_en_in,
  output logic fail_out,
  output int ticks_out
);
  ////////////////////////////////////////////////////////////////////
  // Oscillator reports a failure only while it is meant to run
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fail_out <= 1'b0;
      ticks_out <= 0;
    end else begin
      fail_out <= kill_in & sys_on_in;
      ticks_out <= ticks_out + int'(cpu_en_in);
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Register, doze, power-save and fail-safe tests
`timescale 1ns/1ps
`include "clock_monitor_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end

module testbench;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, lock = 0, mon = 0;
  logic wdt = 0, pll = 0, ps_exec = 0, ps_mode = 0, irq = 0, wdt_to = 0;
  logic kill = 0, fail, trap, pllf, cpu_en, per_en, sys_on, low_power_rc_osc, mact, wclr;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [2:0] csel;
  int n_mismatch = 0, checks = 0, ticks, t0, k;
  logic seen, low;

  always #2.5 clk_in = ~clk_in;

  clock_monitor_power_save_ctrl dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in),
    .config_locked_in(lock), .monitor_enable_in(mon), .wdt_enable_in(wdt),
    .pll_in_use_in(pll), .osc_fail_in(fail), .power_save_exec_in(ps_exec),
    .power_save_mode_in(ps_mode), .irq_in(irq), .wdt_timeout_in(wdt_to),
    .rdata_out(rdata), .clock_select_out(csel), .pll_fallback_out(pllf),
    .fail_trap_out(trap), .cpu_clock_en_out(cpu_en), .periph_clock_en_out(per_en),
    .sys_clock_on_out(sys_on), .low_power_rc_osc_run_out(low_power_rc_osc), .monitor_active_out(mact),
    .wdt_clear_out(wclr));

  osc_core_model far_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .sys_on_in(sys_on),
    .kill_in(kill), .cpu_en_in(cpu_en), .fail_out(fail), .ticks_out(ticks));

  ////////////////////////////////////////////////////////////////////
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in); wr_in <= 1; addr <= a; wdata <= d;
    @(posedge clk_in); wr_in <= 0;
  endtask

  task rd(input logic [3:0] a);
    @(posedge clk_in); rd_in <= 1; addr <= a;
    @(posedge clk_in); rd_in <= 0;
    #1 v = rdata;
  endtask

  task pulse(input logic use_irq);
    @(posedge clk_in); irq <= use_irq; wdt_to <= ~use_irq;
    @(posedge clk_in); irq <= 0; wdt_to <= 0;
  endtask

  task lowp(input logic m, input logic use_irq);
    seen = 0;
    @(posedge clk_in); ps_exec <= 1; ps_mode <= m;
    @(posedge clk_in); ps_exec <= 0;
    #1 seen = wclr;
    repeat (4) begin @(posedge clk_in); #1 seen |= wclr; end
    `CHK("wdt_clear", wdt, seen)
    `CHK("cpu_en", 1'b0, cpu_en)
    `CHK("periph_en", m, per_en)
    `CHK("sys_on", m, sys_on)
    `CHK("low_power_rc_osc", m ? (wdt | mon) : wdt, low_power_rc_osc)
    `CHK("mon_active", m & mon, mact)
    pulse(use_irq);
    k = 0;
    #1 while (cpu_en !== 1'b1 && k < 8) begin @(posedge clk_in); #1 k++; end
    `CHK("wake_time", 1'b1, k >= 2 && k <= 4)
    `CHK("clock_kept", 3'h3, csel)
  endtask

  task give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1;
    rd(`ADDR_CLOCK_DIVISOR); `CHK("div_reset", 16'h0000, v)
    rd(4'hF); `CHK("unmapped", 16'h0000, v)
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_CLOCK_DIVISOR, 16'h0000);
      wr(`ADDR_CLOCK_DIVISOR, {1'b0, 3'(c), 12'h000});
      wr(`ADDR_CLOCK_DIVISOR, {1'b0, 3'(c), 12'h800});
      rd(`ADDR_CLOCK_DIVISOR);
      `CHK("doze_set", {1'b0, 3'(c), c != 0, 11'h0}, v)
      repeat (4) @(posedge clk_in);
      t0 = ticks;
      repeat (128) @(posedge clk_in);
      `CHK("cpu_ticks", 128 >> c, ticks - t0)
      `CHK("periph_full", 1'b1, per_en)
    end
    wr(`ADDR_CLOCK_DIVISOR, 16'h1800);
    rd(`ADDR_CLOCK_DIVISOR); `CHK("ratio_locked", 16'h7800, v)
    wr(`ADDR_CLOCK_DIVISOR, 16'hF800); pulse(1);
    rd(`ADDR_CLOCK_DIVISOR); `CHK("recover", 16'hF000, v)
    wr(`ADDR_CLOCK_DIVISOR, 16'h7800); pulse(1);
    rd(`ADDR_CLOCK_DIVISOR); `CHK("no_recover", 16'h7800, v)
    wr(`ADDR_CLOCK_DIVISOR, 16'h0000);
    wr(`ADDR_OSC_CONTROL, 16'h0300);
    lock <= 1; wr(`ADDR_OSC_CONTROL, 16'h0500); lock <= 0;
    rd(`ADDR_OSC_CONTROL); `CHK("osc_locked", 16'h0300, v)
    `CHK("osc_sel", 3'h3, csel)
    mon <= 1; wdt <= 0; lowp(1, 1);
    wdt <= 1; lowp(0, 0);
    mon <= 0; lowp(1, 0);
    wdt <= 0; lowp(0, 1);
    low = 0;
    @(posedge clk_in); ps_exec <= 1; ps_mode <= 1; irq <= 1;
    @(posedge clk_in); ps_exec <= 0; irq <= 0;
    repeat (10) begin @(posedge clk_in); #1 low |= ~cpu_en; end
    `CHK("deferred_wake", 2'b11, {low, cpu_en})
    mon <= 1; pll <= 1;
    repeat (2) @(posedge clk_in);
    `CHK("low_power_rc_osc_mon", 1'b1, low_power_rc_osc)
    kill <= 1; seen = 0;
    repeat (8) begin @(posedge clk_in); #1 seen |= trap; end
    `CHK("fail_trap", 1'b1, seen)
    `CHK("fallback_sel", `OSC_SEL_FAST_RC, csel)
    `CHK("fallback_pll", 1'b1, pllf)
    kill <= 0; repeat (4) @(posedge clk_in);
    rd(`ADDR_OSC_CONTROL); `CHK("fail_flag", 1'b1, v[`OSC_CLK_FAIL_BIT])
    rd(`ADDR_OSC_CONTROL); `CHK("flag_holds", 1'b1, v[`OSC_CLK_FAIL_BIT])
    wr(`ADDR_OSC_CONTROL, 16'h0000);
    rd(`ADDR_OSC_CONTROL); `CHK("flag_clear", 1'b0, v[`OSC_CLK_FAIL_BIT])
    give_verdict;
  end
endmodule
